// ### src/nsf_formatter.sv
`timescale 1ns/10ps
module nsf_formatter
  import nsf_pkg::*;
#(
  parameter logic [TICK_W-1:0] P_INTERVAL_CYC = TICK_W'(INTERVAL_CYC)
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Navigation result, BCD digits
  input  wire logic [7:0]  i_hour,
  input  wire logic [7:0]  i_min,
  input  wire logic [7:0]  i_sec,
  input  wire logic [7:0]  i_lat_deg,
  input  wire logic [7:0]  i_lat_min,
  input  wire logic [7:0]  i_lat_frac,
  input  wire logic        i_lat_south,
  input  wire logic [11:0] i_lon_deg,
  input  wire logic [7:0]  i_lon_min,
  input  wire logic [7:0]  i_lon_frac,
  input  wire logic        i_lon_west,
  input  wire logic        i_fix_valid,
  input  wire logic        i_frac_en,
  // Selection configuration
  input  wire logic [6:0]  i_nv_sel,
  input  wire logic        i_nv_valid,
  input  wire logic        i_cfg_wr,
  input  wire logic [6:0]  i_cfg_sel,
  input  wire logic        i_cfg_save,
  input  wire logic        i_cfg_factory,
  output logic             o_nv_wr,
  output logic       [6:0] o_nv_sel,
  output logic             o_nv_valid,
  output logic       [6:0] o_sel,
  // Character stream to the serial talker
  output logic       [7:0] o_char,
  output logic             o_char_valid,
  input  wire logic        i_char_ready,
  // Status
  output logic             o_busy,
  output logic             o_overrun
);
  typedef struct packed {
    nsf_state_type     st;
    logic [TICK_W-1:0] tick_cnt;
    logic [6:0]        mask;
    logic [2:0]        idx;
    logic [5:0]        pos;
    logic [7:0]        cs;
    logic [7:0]        hour;
    logic [7:0]        min;
    logic [7:0]        sec;
    logic [7:0]        lat_deg;
    logic [7:0]        lat_min;
    logic [7:0]        lat_frac;
    logic              south;
    logic [11:0]       lon_deg;
    logic [7:0]        lon_min;
    logic [7:0]        lon_frac;
    logic              west;
    logic              fix;
    logic              frac;
    logic [7:0]        och;
    logic              ovalid;
    logic [5:0]        opos;
    logic              overrun;
    logic [6:0]        len;
  } nsf_fmt_type;

  nsf_fmt_type s, next_s;
  logic [6:0]  sel;
  logic [7:0]  cs_hi_char;
  logic [7:0]  cs_lo_char;
  logic [7:0]  ch;
  logic [23:0] name;
  logic        tick;
  logic        hs;

  function automatic logic [2:0] lowest(input logic [6:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = MSG_COUNT - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : lowest

  nsf_sel_store u_sel (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_nv_sel      (i_nv_sel),
    .i_nv_valid    (i_nv_valid),
    .i_cfg_wr      (i_cfg_wr),
    .i_cfg_sel     (i_cfg_sel),
    .i_cfg_save    (i_cfg_save),
    .i_cfg_factory (i_cfg_factory),
    .o_sel         (sel),
    .o_nv_wr       (o_nv_wr),
    .o_nv_sel      (o_nv_sel),
    .o_nv_valid    (o_nv_valid)
  );

  nsf_hex_char u_cs_hi (
    .i_nib  (s.cs[7:4]),
    .o_char (cs_hi_char)
  );
  nsf_hex_char u_cs_lo (
    .i_nib  (s.cs[3:0]),
    .o_char (cs_lo_char)
  );

  assign name = MSG_NAME[s.idx];
  assign hs = s.ovalid && i_char_ready;

  // Character at the current position
  always_comb begin
    ch = CH_COMMA;
    case (s.pos)
      POS_SOF:         ch = CH_DOLLAR;
      POS_STAR:        ch = CH_STAR;
      POS_CR:          ch = CH_CR;
      POS_LF:          ch = CH_LF;
      POS_TALK:        ch = CH_UG;
      POS_TALK + 6'h1: ch = CH_UP;
      POS_MSG:         ch = name[23:16];
      POS_MSG + 6'h1:  ch = name[15:8];
      POS_MSG + 6'h2:  ch = name[7:0];
      POS_TIME:        ch = nsf_dig(s.hour[7:4]);
      POS_TIME + 6'h1: ch = nsf_dig(s.hour[3:0]);
      POS_TIME + 6'h2: ch = nsf_dig(s.min[7:4]);
      POS_TIME + 6'h3: ch = nsf_dig(s.min[3:0]);
      POS_TIME + 6'h4: ch = nsf_dig(s.sec[7:4]);
      POS_TIME + 6'h5: ch = nsf_dig(s.sec[3:0]);
      POS_LAT:         ch = nsf_dig(s.lat_deg[7:4]);
      POS_LAT + 6'h1:  ch = nsf_dig(s.lat_deg[3:0]);
      POS_LAT + 6'h2:  ch = nsf_dig(s.lat_min[7:4]);
      POS_LAT + 6'h3:  ch = nsf_dig(s.lat_min[3:0]);
      POS_LATP:        ch = CH_POINT;
      POS_LATP + 6'h1: ch = nsf_dig(s.lat_frac[7:4]);
      POS_LATP + 6'h2: ch = nsf_dig(s.lat_frac[3:0]);
      POS_NS:          ch = s.south ? CH_US : CH_UN;
      POS_LON:         ch = nsf_dig(s.lon_deg[11:8]);
      POS_LON + 6'h1:  ch = nsf_dig(s.lon_deg[7:4]);
      POS_LON + 6'h2:  ch = nsf_dig(s.lon_deg[3:0]);
      POS_LON + 6'h3:  ch = nsf_dig(s.lon_min[7:4]);
      POS_LON + 6'h4:  ch = nsf_dig(s.lon_min[3:0]);
      POS_LONP:        ch = CH_POINT;
      POS_LONP + 6'h1: ch = nsf_dig(s.lon_frac[7:4]);
      POS_LONP + 6'h2: ch = nsf_dig(s.lon_frac[3:0]);
      POS_EW:          ch = s.west ? CH_UW : CH_UE;
      POS_STAT:        ch = s.fix ? CH_UA : CH_UV;
      POS_CSH:         ch = cs_hi_char;
      POS_CSL:         ch = cs_lo_char;
      default:         ch = CH_COMMA;
    endcase
  end

  // Interval counter
  assign tick = (s.tick_cnt == P_INTERVAL_CYC - TICK_W'(1));

  always_comb begin
    next_s = s;
    next_s.overrun = 1'b0;
    next_s.tick_cnt = tick ? '0 : s.tick_cnt + TICK_W'(1);
    if (tick && s.st != ST_WAIT) begin
      next_s.overrun = 1'b1;
    end
    if (hs) begin
      next_s.ovalid = 1'b0;
      next_s.len = (s.opos == POS_SOF) ? 7'h00 : s.len + 7'h01;
    end
    case (s.st)
      ST_WAIT: begin
        if (tick) begin
          next_s.st = ST_PICK;
          next_s.mask = sel;
          next_s.hour = i_hour;
          next_s.min = i_min;
          next_s.sec = i_sec;
          next_s.lat_deg = i_lat_deg;
          next_s.lat_min = i_lat_min;
          next_s.lat_frac = i_lat_frac;
          next_s.south = i_lat_south;
          next_s.lon_deg = i_lon_deg;
          next_s.lon_min = i_lon_min;
          next_s.lon_frac = i_lon_frac;
          next_s.west = i_lon_west;
          next_s.fix = i_fix_valid;
          next_s.frac = i_frac_en;
        end
      end
      ST_PICK: begin
        if (s.mask == 7'h00) begin
          next_s.st = ST_WAIT;
        end else begin
          next_s.idx = lowest(s.mask);
          next_s.mask[lowest(s.mask)] = 1'b0;
          next_s.pos = POS_SOF;
          next_s.cs = 8'h00;
          next_s.st = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!s.ovalid || i_char_ready) begin
          next_s.och = ch;
          next_s.ovalid = 1'b1;
          next_s.opos = s.pos;
          if (s.pos >= POS_TALK && s.pos < POS_STAR) begin
            next_s.cs = s.cs ^ ch;
          end
          next_s.pos = s.pos + 6'h1;
          if (!s.frac && s.pos == POS_LATP - 6'h1) begin
            next_s.pos = POS_NS - 6'h1;
          end
          if (!s.frac && s.pos == POS_LONP - 6'h1) begin
            next_s.pos = POS_EW - 6'h1;
          end
          if (s.pos == POS_LF) begin
            next_s.st = ST_PICK;
          end
        end
      end
      default: next_s.st = ST_WAIT;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_char = s.och;
  assign o_char_valid = s.ovalid;
  assign o_busy = (s.st != ST_WAIT);
  assign o_overrun = s.overrun;
  assign o_sel = sel;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_status_char: assert property (
    (s.ovalid && s.opos == POS_STAT) |->
      (o_char == (s.fix ? CH_UA : CH_UV)))
    else $error("status character wrong");
  a_lat_digits: assert property (
    (s.ovalid && s.opos >= POS_LAT && s.opos < POS_LATP) |->
      (o_char >= CH_ZERO && o_char <= CH_NINE))
    else $error("latitude digit wrong");
  a_lon_digits: assert property (
    (s.ovalid && s.opos >= POS_LON && s.opos < POS_LONP) |->
      (o_char >= CH_ZERO && o_char <= CH_NINE))
    else $error("longitude digit wrong");
  a_time_digits: assert property (
    (s.ovalid && s.opos >= POS_TIME && s.opos < POS_LAT - 6'h1) |->
      (o_char >= CH_ZERO && o_char <= CH_NINE))
    else $error("time digit wrong");
  a_frac_skip: assert property (
    (hs && !s.frac && s.st == ST_SEND && s.opos == POS_LATP - 6'h1) |=>
      (s.opos == POS_NS - 6'h1))
    else $error("latitude fraction not dropped");
  a_no_space: assert property (
    s.ovalid |-> (o_char != CH_SPACE))
    else $error("space in sentence");
  a_cs_pair: assert property (
    (hs && s.opos == POS_STAR) |=> (s.opos == POS_CSH) ##1
      (!s.ovalid || s.opos == POS_CSH || s.opos == POS_CSL))
    else $error("checksum pair broken");
  a_start_char: assert property (
    (s.ovalid && s.opos == POS_SOF) |-> (o_char == CH_DOLLAR))
    else $error("sentence start wrong");
  a_end_pair: assert property (
    (hs && s.opos == POS_CR) |=> s.ovalid && (o_char == CH_LF))
    else $error("line feed missing after CR");
  a_sentence_len: assert property (
    (hs && s.opos == POS_CR) |-> (s.len <= MAX_LEN))
    else $error("sentence too long");
  a_tick_start: assert property (
    (tick && s.st == ST_WAIT) |=> (s.st == ST_PICK) && (s.mask == $past(sel)))
    else $error("interval did not start output");
  a_cs_hex_hi: assert property (
    (cs_hi_char >= CH_ZERO && cs_hi_char <= CH_NINE) ||
    (cs_hi_char >= CH_UA && cs_hi_char <= CH_UF))
    else $error("checksum high digit not hex");
  a_cs_hex_lo: assert property (
    (cs_lo_char >= CH_ZERO && cs_lo_char <= CH_NINE) ||
    (cs_lo_char >= CH_UA && cs_lo_char <= CH_UF))
    else $error("checksum low digit not hex");
  a_name_alpha: assert property (
    (s.ovalid && s.opos >= POS_MSG && s.opos < POS_MSG + 6'h3) |->
      (o_char >= CH_UA && o_char <= 8'h5a))
    else $error("sentence name not letters");
endmodule : nsf_formatter

// ### src/nsf_pkg.sv
package nsf_pkg;
  // Interval timing
  localparam int unsigned INTERVAL_S   = 1;
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned INTERVAL_CYC = INTERVAL_S * CLK_HZ;
  localparam int unsigned TICK_W       = 24;

  // Sentence selection, one bit per sentence type
  localparam int unsigned MSG_COUNT = 7;
  localparam logic [6:0] SEL_DEFAULT = 7'h21;
  localparam logic [23:0] MSG_NAME [0:6] = '{
    "GGA", "GLL", "GSA", "GSV", "RMC", "VTG", "ZDA"
  };

  // Character positions within a sentence
  localparam logic [5:0] POS_SOF  = 6'h00;
  localparam logic [5:0] POS_TALK = 6'h01;
  localparam logic [5:0] POS_MSG  = 6'h03;
  localparam logic [5:0] POS_TIME = 6'h07;
  localparam logic [5:0] POS_LAT  = 6'h0e;
  localparam logic [5:0] POS_LATP = 6'h12;
  localparam logic [5:0] POS_NS   = 6'h16;
  localparam logic [5:0] POS_LON  = 6'h18;
  localparam logic [5:0] POS_LONP = 6'h1d;
  localparam logic [5:0] POS_EW   = 6'h21;
  localparam logic [5:0] POS_STAT = 6'h23;
  localparam logic [5:0] POS_STAR = 6'h24;
  localparam logic [5:0] POS_CSH  = 6'h25;
  localparam logic [5:0] POS_CSL  = 6'h26;
  localparam logic [5:0] POS_CR   = 6'h27;
  localparam logic [5:0] POS_LF   = 6'h28;
  localparam logic [6:0] MAX_LEN  = 7'h4f;

  // Character codes
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_COMMA  = 8'h2c;
  localparam logic [7:0] CH_POINT  = 8'h2e;
  localparam logic [7:0] CH_STAR   = 8'h2a;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_LF     = 8'h0a;
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_UA     = 8'h41;
  localparam logic [7:0] CH_UF     = 8'h46;
  localparam logic [7:0] CH_UG     = 8'h47;
  localparam logic [7:0] CH_UP     = 8'h50;
  localparam logic [7:0] CH_UV     = 8'h56;
  localparam logic [7:0] CH_UN     = 8'h4e;
  localparam logic [7:0] CH_US     = 8'h53;
  localparam logic [7:0] CH_UE     = 8'h45;
  localparam logic [7:0] CH_UW     = 8'h57;

  typedef enum logic [1:0] {ST_WAIT, ST_PICK, ST_SEND} nsf_state_type;

  function automatic logic [7:0] nsf_dig(input logic [3:0] n);
    return CH_ZERO + {4'h0, n};
  endfunction : nsf_dig
endpackage : nsf_pkg

// ### src/nsf_hex_char.sv
`timescale 1ns/10ps
module nsf_hex_char
  import nsf_pkg::*;
(
  // Nibble in, ASCII out
  input  wire logic [3:0] i_nib,
  output logic      [7:0] o_char
);
  always_comb begin
    if (i_nib < 4'ha) begin
      o_char = nsf_dig(i_nib);
    end else begin
      o_char = CH_UA + {4'h0, i_nib - 4'ha};
    end
  end
endmodule : nsf_hex_char

// ### src/nsf_sel_store.sv
`timescale 1ns/10ps
module nsf_sel_store
  import nsf_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Stored selection seen at restart
  input  wire logic [6:0] i_nv_sel,
  input  wire logic       i_nv_valid,
  // Configuration requests
  input  wire logic       i_cfg_wr,
  input  wire logic [6:0] i_cfg_sel,
  input  wire logic       i_cfg_save,
  input  wire logic       i_cfg_factory,
  // Active selection and store write
  output logic      [6:0] o_sel,
  output logic            o_nv_wr,
  output logic      [6:0] o_nv_sel,
  output logic            o_nv_valid
);
  typedef struct packed {
    logic       boot;
    logic [6:0] sel;
    logic       nv_wr;
    logic [6:0] nv_sel;
    logic       nv_valid;
  } nsf_sel_type;

  nsf_sel_type s, next_s;

  always_comb begin
    next_s = s;
    next_s.nv_wr = 1'b0;
    next_s.boot = 1'b0;
    if (s.boot) begin
      next_s.sel = i_nv_valid ? i_nv_sel : SEL_DEFAULT;
    end else if (i_cfg_factory) begin
      next_s.sel = SEL_DEFAULT;
      next_s.nv_wr = 1'b1;
      next_s.nv_sel = SEL_DEFAULT;
      next_s.nv_valid = 1'b0;
    end else if (i_cfg_save) begin
      next_s.nv_wr = 1'b1;
      next_s.nv_sel = s.sel;
      next_s.nv_valid = 1'b1;
    end else if (i_cfg_wr) begin
      next_s.sel = i_cfg_sel;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s <= '{boot: 1'b1, sel: SEL_DEFAULT, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign o_sel = s.sel;
  assign o_nv_wr = s.nv_wr;
  assign o_nv_sel = s.nv_sel;
  assign o_nv_valid = s.nv_valid;

  a_restart_sel: assert property (@(posedge i_clk)
    $fell(i_rst) |-> ##1 (o_sel == (i_nv_valid ? i_nv_sel : SEL_DEFAULT)))
    else $error("restart selection wrong");
  a_factory_sel: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cfg_factory && !s.boot) |=> (o_sel == SEL_DEFAULT) && o_nv_wr
      && !o_nv_valid)
    else $error("factory restore incomplete");
endmodule : nsf_sel_store

// ### testbench/nsf_listener.sv
`timescale 1ns/10ps
module nsf_listener
  import nsf_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Character stream
  input  wire logic [7:0] i_char,
  input  wire logic       i_char_valid,
  output logic            o_char_ready,
  // Pacing
  input  wire logic       i_slow,
  input  wire logic       i_hold
);
  logic [639:0] body;
  logic [639:0] last_body;
  logic [15:0]  cs_txt;
  logic [15:0]  last_cs;
  int           stage     = 0;
  int           len       = 0;
  int           nf        = 0;
  int           n_sp      = 0;
  int           last_len  = 0;
  int           last_nf   = 0;
  int           last_sp   = 0;
  int           n_lines   = 0;
  int           n_bad     = 0;

  task automatic take(input logic [7:0] c);
    case (stage)
      0: begin
        if (c === CH_DOLLAR) begin
          body  = '0;
          len   = 0;
          nf    = 1;
          n_sp  = 0;
          stage = 1;
        end else begin
          n_bad++;
        end
      end
      1: begin
        if (c === CH_STAR) begin
          stage = 2;
        end else begin
          body = {body[631:0], c};
          len++;
          if (c === CH_COMMA) nf++;
          if (c === CH_SPACE) n_sp++;
        end
      end
      2: begin
        cs_txt[15:8] = c;
        stage        = 3;
      end
      3: begin
        cs_txt[7:0] = c;
        stage       = 4;
      end
      4: begin
        if (c !== CH_CR) n_bad++;
        stage = (c === CH_CR) ? 5 : 0;
      end
      default: begin
        if (c === CH_LF) begin
          last_body = body;
          last_cs   = cs_txt;
          last_len  = len;
          last_nf   = nf;
          last_sp   = n_sp;
          n_lines++;
        end else begin
          n_bad++;
        end
        stage = 0;
      end
    endcase
  endtask : take

  // Hold stalls fully, slow every other cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_char_ready <= 1'b0;
      stage = 0;
    end else begin
      o_char_ready <= i_hold ? 1'b0 : (i_slow ? ~o_char_ready : 1'b1);
      if (i_char_valid && o_char_ready) take(i_char);
    end
  end
endmodule : nsf_listener

// ### testbench/nsf_formatter_tb_top.sv
`timescale 1ns/10ps
module nsf_formatter_tb_top
  import nsf_pkg::*;
();
  // interval leaves room for seven slow sentences
  localparam logic [23:0] INTERVAL = 24'h0003e8;
  localparam logic [511:0] T1 = ",010203,0507,N,00908,E,A";
  localparam logic [511:0] T2 = ",235958,0507.12,S,00908.34,W,V";

  logic        i_clk, i_rst, south, west, fix, frac_en, slow;
  logic [7:0]  hour, min, sec, lat_deg, lat_min, lat_frac, lon_min, lon_frac;
  logic [11:0] lon_deg;
  logic        cfg_wr, cfg_save, cfg_factory, nv_wr, w_nv_valid, hold;
  logic        nv_valid = 1'b0;
  logic [6:0]  cfg_sel, w_nv_sel, sel;
  logic [6:0]  nv_sel = 7'h00;
  logic [7:0]  ch;
  logic        ch_valid, ch_ready, busy, overrun;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;

  nsf_formatter #(.P_INTERVAL_CYC(INTERVAL)) i_nsf_formatter (
    .i_clk(i_clk), .i_rst(i_rst), .i_hour(hour), .i_min(min), .i_sec(sec),
    .i_lat_deg(lat_deg), .i_lat_min(lat_min), .i_lat_frac(lat_frac),
    .i_lat_south(south), .i_lon_deg(lon_deg), .i_lon_min(lon_min),
    .i_lon_frac(lon_frac), .i_lon_west(west), .i_fix_valid(fix),
    .i_frac_en(frac_en), .i_nv_sel(nv_sel), .i_nv_valid(nv_valid),
    .i_cfg_wr(cfg_wr), .i_cfg_sel(cfg_sel), .i_cfg_save(cfg_save),
    .i_cfg_factory(cfg_factory), .o_nv_wr(nv_wr), .o_nv_sel(w_nv_sel),
    .o_nv_valid(w_nv_valid), .o_sel(sel), .o_char(ch),
    .o_char_valid(ch_valid), .i_char_ready(ch_ready), .o_busy(busy),
    .o_overrun(overrun));

  nsf_listener i_nsf_listener (
    .i_clk(i_clk), .i_rst(i_rst), .i_char(ch), .i_char_valid(ch_valid),
    .o_char_ready(ch_ready), .i_slow(slow), .i_hold(hold));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // Nonvolatile store model
  always @(posedge i_clk) begin
    if (nv_wr) begin
      nv_sel   <= w_nv_sel;
      nv_valid <= w_nv_valid;
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [639:0] seen, exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check

  function automatic logic [7:0] hex(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction : hex

  function automatic logic [639:0] mk(input int i, input logic [511:0] t);
    int n;
    n = 0;
    for (int b = 0; b < 64; b++) if (t[b*8 +: 8] != 8'h00) n = b + 1;
    return (640'({"GP", MSG_NAME[i]}) << (8 * n)) | 640'(t);
  endfunction : mk

  task automatic wait_msg(input int i, input logic [511:0] t);
    logic [639:0] e;
    logic [7:0]   x;
    int           n0;
    int           k;
    e  = mk(i, t);
    x  = 8'h00;
    for (int b = 0; b < 80; b++) x ^= e[b*8 +: 8];
    n0 = i_nsf_listener.n_lines;
    k  = 0;
    while (i_nsf_listener.n_lines == n0 && k < 4000) begin
      @(negedge i_clk);
      k++;
    end
    check(k < 4000, 1, "sentence missing");
    check(i_nsf_listener.last_body, e, "sentence text");
    check(i_nsf_listener.last_cs, {hex(x[7:4]), hex(x[3:0])}, "sum");
    check(i_nsf_listener.last_len + 3 > 79, 0, "too long");
    check(i_nsf_listener.last_sp, 0, "space seen");
    check(i_nsf_listener.last_nf, 7, "field count");
    check(i_nsf_listener.n_bad, 0, "framing");
  endtask : wait_msg

  task automatic do_reset();
    @(negedge i_clk);
    i_rst = 1'b1;
    repeat (10) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask : do_reset

  task automatic pulse(input int what, input logic [6:0] s);
    @(negedge i_clk);
    cfg_sel     = s;
    cfg_wr      = (what == 0);
    cfg_save    = (what == 1);
    cfg_factory = (what == 2);
    @(negedge i_clk);
    {cfg_wr, cfg_save, cfg_factory} = 3'h0;
  endtask : pulse

  task automatic t_default();
    check(sel, 7'h21, "reset selection");
    check(ch_valid, 0, "idle stream");
    wait_msg(0, T1);
    wait_msg(5, T1);
    $display("test default done");
  endtask : t_default

  task automatic t_frac();
    {hour, min, sec} = 24'h235958;
    {south, west, fix, frac_en, slow} = 5'h1b;
    wait_msg(0, T2);
    wait_msg(5, T2);
    $display("test fraction done");
  endtask : t_frac

  task automatic t_all();
    pulse(0, 7'h7f);
    check(sel, 7'h7f, "selection written");
    for (int i = 0; i < 7; i++) wait_msg(i, T2);
    $display("test all types done");
  endtask : t_all

  task automatic t_store();
    pulse(0, 7'h12);
    pulse(1, 7'h00);
    check({nv_wr, w_nv_valid, w_nv_sel}, 9'h192, "store write");
    do_reset();
    check(sel, 7'h12, "stored selection");
    wait_msg(1, T2);
    wait_msg(4, T2);
    pulse(2, 7'h00);
    check({w_nv_valid, sel}, 8'h21, "factory restore");
    do_reset();
    check(sel, 7'h21, "defaults back");
    $display("test store done");
  endtask : t_store

  task automatic t_overrun();
    int k;
    k = 0;
    hold = 1'b1;
    while (busy !== 1'b1 && k < 1100) begin
      @(negedge i_clk);
      k++;
    end
    check(busy, 1, "stalled sentence");
    k = 0;
    while (overrun !== 1'b1 && k < 1100) begin
      @(negedge i_clk);
      k++;
    end
    check(overrun, 1, "interval overrun");
    hold = 1'b0;
    wait_msg(0, T2);
    wait_msg(5, T2);
    check(busy, 0, "idle after output");
    $display("test overrun done");
  endtask : t_overrun

  initial begin
    i_rst = 1'b1;
    {hour, min, sec} = 24'h010203;
    {lat_deg, lat_min, lat_frac} = 24'h050712;
    {lon_deg, lon_min, lon_frac} = 28'h0090834;
    {south, west, fix, frac_en, slow} = 5'h04;
    {cfg_wr, cfg_save, cfg_factory, hold} = 4'h0;
    cfg_sel = 7'h00;
    do_reset();
    t_default();
    t_frac();
    t_all();
    t_store();
    t_overrun();
    stop_test();
  end
endmodule : nsf_formatter_tb_top
